// ===== verilog/wdt_pkg.sv
// Register map, field layout and timing constants of the watchdog
package wdt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CONTROL               = 4'h0;
  localparam logic [3:0] IDX_TIMING_CONFIG         = 4'h1;
  localparam logic [3:0] IDX_EARLY_WARNING_CONTROL = 4'h2;
  localparam logic [3:0] IDX_IRQ_ENABLE_CLEAR      = 4'h4;
  localparam logic [3:0] IDX_IRQ_ENABLE_SET        = 4'h5;
  localparam logic [3:0] IDX_IRQ_FLAGS             = 4'h6;
  localparam logic [3:0] IDX_SYNC_STATUS           = 4'h7;
  localparam logic [3:0] IDX_SERVICE_KEY           = 4'h8;
  localparam int         IDX_LSB                   = 2;

  // Field positions
  localparam int CTRL_ENABLE_BIT  = 1;
  localparam int CTRL_WINDOW_BIT  = 2;
  localparam int CFG_WINDOW_LSB   = 4;
  localparam int CFG_TIMEOUT_LSB  = 0;
  localparam int EARLY_WARN_BIT   = 0;
  localparam int SYNC_BUSY_BIT    = 7;

  // Values
  localparam logic [7:0] CTRL_MASK          = 8'h06;
  localparam logic [3:0] CODE_MAX           = 4'hb;
  localparam logic [7:0] SERVICE_KEY_VALUE  = 8'ha5;
  localparam logic [7:0] SERVICE_KEY_RESET  = 8'h00;
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [15:0] BASE_LEN          = 16'h0008;

  // Cross-domain transfer time
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         SYNC_TIME_NS  = 30;
  localparam int         SYNC_CYCLES   =
    (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SYNC_LOAD     = 2'(SYNC_CYCLES);

  // Bus address phase held over into the data phase
  typedef struct packed {
    logic       vld;
    logic       wr;
    logic [3:0] idx;
  } bus_phase_t;

endpackage : wdt_pkg

// ===== verilog/wdt_core.sv
// Watchdog timer with AHB-Lite register slave
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ns

// Summary of operation
// [RQ1] Window bits 7:4 give closed window of 8<<n ticks; C-F reserved
// [RQ2] Period bits 3:0 give time-out of 8<<n ticks; C-F reserved
// [RQ3] In window mode the period field sets the open window length
// [RQ4] Early warning fires offset ticks (8<<n) after the period starts
// [RQ5] Window, period and offset load from stored configuration at start-up
// [RQ6] Config is protected and synchronised; warning control protected only
// [RQ7] Writing one to enable-clear bit 0 disables the warning interrupt
// [RQ8] Writing one to enable-set bit 0 enables the warning interrupt
// [RQ9] Warning flag bit 0 sets when the warning point is reached
// [RQ10] Writing one to the warning flag clears it; zero leaves it
// [RQ11] Status bit 7 is busy while a cross-domain transfer is in flight
// [RQ12] Writing the key to the service register restarts the count
// [RQ13] Writing any other service value issues a system reset
// [RQ14] Service register: write-only, protected, synchronised, resets to zero
// [RQ15] In window mode the warning fires when the open window begins
// [RQ16] Offset beyond the period means time-out reset comes first, no warning
// [RQ17] Interrupt is high while flag and enable are both set
// [RQ18] Enable-protected registers take writes only while watchdog is off
// [RQ19] Normal mode resets the system when the period elapses unserviced
// [RQ20] Key write inside the closed window is a violation and resets
// [RQ21] Software services only in the open window or before time-out
module wdt_core
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Watchdog tick, protection and start-up values
  input  wire logic        watchdog_count_clock,
  input  wire logic        write_lock,
  input  wire logic [7:0]  nvm_control,
  input  wire logic [7:0]  nvm_timing_config,
  input  wire logic [3:0]  nvm_early_warn_offset,
  // Requests to the system
  output logic             irq,
  output logic             sys_reset_req
);

  function automatic logic [15:0] code_len(input logic [3:0] code);
    logic [3:0] c;
    c = (code > CODE_MAX) ? CODE_MAX : code;
    return BASE_LEN << c;
  endfunction : code_len

  logic        rst_s1_q;
  logic        rst_n;
  logic        loaded_q;
  bus_phase_t  ph_q;
  logic [31:0] hrdata_q;
  logic        hready_q;
  logic        hresp_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_act_q;
  logic [7:0]  cfg_q;
  logic [7:0]  cfg_act_q;
  logic [3:0]  early_warn_offset_q;
  logic        ien_q;
  logic        early_warn_q;
  logic        busy_q;
  logic [1:0]  sync_cnt_q;
  logic [3:0]  pend_idx_q;
  logic [7:0]  pend_data_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        irq_q;
  logic        sys_reset_q;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Bus decode
  wire [3:0] a_idx   = haddr[IDX_LSB+3:IDX_LSB];
  wire       accept  = hsel & htrans[1] & hready;
  wire       a_sync  = (a_idx == IDX_CONTROL) |
                       (a_idx == IDX_TIMING_CONFIG) |
                       (a_idx == IDX_SERVICE_KEY);
  wire       wr_en   = ph_q.vld & ph_q.wr & hready_q;
  wire [7:0] wdat    = hwdata[7:0];
  wire       prot_ok = ~write_lock;
  wire       wdt_off = ~ctrl_q[CTRL_ENABLE_BIT] &
                       ~ctrl_act_q[CTRL_ENABLE_BIT];
  wire       ena_ok  = prot_ok & wdt_off;                   // [RQ18]
  wire       wr_ctrl = wr_en & (ph_q.idx == IDX_CONTROL) & prot_ok;
  wire       wr_cfg  = wr_en & (ph_q.idx == IDX_TIMING_CONFIG) & ena_ok;
  wire       wr_woff = wr_en & (ph_q.idx == IDX_EARLY_WARNING_CONTROL)
                       & ena_ok;                            // [RQ6]
  wire       wr_iclr = wr_en & (ph_q.idx == IDX_IRQ_ENABLE_CLEAR) & prot_ok;
  wire       wr_iset = wr_en & (ph_q.idx == IDX_IRQ_ENABLE_SET) & prot_ok;
  wire       wr_flag = wr_en & (ph_q.idx == IDX_IRQ_FLAGS);
  wire       wr_svc  = wr_en & (ph_q.idx == IDX_SERVICE_KEY) & prot_ok;
  wire       sync_start = wr_ctrl | wr_cfg | wr_svc;        // [RQ6] [RQ14]
  wire       sync_done  = busy_q & (sync_cnt_q == 2'd1);
  wire       stall_new  = accept & hwrite & a_sync & (busy_q | sync_start);

  // Read mux, service register reads as zero
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (a_idx)
      IDX_CONTROL:               rdata[7:0] = ctrl_q;
      IDX_TIMING_CONFIG:         rdata[7:0] = cfg_q;
      IDX_EARLY_WARNING_CONTROL: rdata[3:0] = early_warn_offset_q;
      IDX_IRQ_ENABLE_CLEAR:      rdata[EARLY_WARN_BIT] = ien_q;   // [RQ7]
      IDX_IRQ_ENABLE_SET:        rdata[EARLY_WARN_BIT] = ien_q;   // [RQ8]
      IDX_IRQ_FLAGS:             rdata[EARLY_WARN_BIT] = early_warn_q;
      IDX_SYNC_STATUS:           rdata[SYNC_BUSY_BIT] = busy_q;   // [RQ11]
      default:                   rdata = 32'h0000_0000;           // [RQ14]
    endcase
  end

  // Bus slave state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q     <= '0;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
    end else begin
      if (hready)
        ph_q <= '{vld: accept, wr: hwrite, idx: a_idx};
      if (accept && !hwrite)
        hrdata_q <= rdata;
      if (stall_new)
        hready_q <= 1'b0;
      else if (!hready_q && !busy_q)
        hready_q <= 1'b1;
    end
  end

  // Synchronisation of control, config and service writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q      <= 1'b0;
      sync_cnt_q  <= 2'd0;
      pend_idx_q  <= 4'h0;
      pend_data_q <= SERVICE_KEY_RESET;                     // [RQ14]
    end else if (sync_start) begin
      busy_q      <= 1'b1;                                  // [RQ11]
      sync_cnt_q  <= SYNC_LOAD;
      pend_idx_q  <= ph_q.idx;
      pend_data_q <= wdat;
    end else if (busy_q) begin
      sync_cnt_q  <= sync_cnt_q - 2'd1;
      if (sync_done)
        busy_q <= 1'b0;                                     // [RQ11]
    end
  end

  // Configuration registers, loaded once after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_q            <= 1'b0;
      ctrl_q              <= REG_RESET;
      ctrl_act_q          <= REG_RESET;
      cfg_q               <= REG_RESET;
      cfg_act_q           <= REG_RESET;
      early_warn_offset_q <= 4'h0;
    end else if (!loaded_q) begin
      loaded_q            <= 1'b1;                          // [RQ5]
      ctrl_q              <= nvm_control & CTRL_MASK;
      ctrl_act_q          <= nvm_control & CTRL_MASK;
      cfg_q               <= nvm_timing_config;
      cfg_act_q           <= nvm_timing_config;
      early_warn_offset_q <= nvm_early_warn_offset;
    end else begin
      if (wr_ctrl)
        ctrl_q <= wdat & CTRL_MASK;
      if (wr_cfg)
        cfg_q <= wdat;                                      // [RQ6]
      if (wr_woff)
        early_warn_offset_q <= wdat[3:0];                   // [RQ6]
      if (sync_done && pend_idx_q == IDX_CONTROL)
        ctrl_act_q <= pend_data_q & CTRL_MASK;
      if (sync_done && pend_idx_q == IDX_TIMING_CONFIG)
        cfg_act_q <= pend_data_q;                           // [RQ6]
    end
  end

  // Counting
  wire        run      = ctrl_act_q[CTRL_ENABLE_BIT];
  wire        win_mode = ctrl_act_q[CTRL_WINDOW_BIT];
  wire [15:0] win_len  = code_len(cfg_act_q[CFG_WINDOW_LSB+3:CFG_WINDOW_LSB]);
  wire [15:0] timeout_len =
    code_len(cfg_act_q[CFG_TIMEOUT_LSB+3:CFG_TIMEOUT_LSB]);   // [RQ1] [RQ2]
  wire [15:0] warn_len = code_len(early_warn_offset_q);     // [RQ4]
  wire [15:0] to_total = win_mode ? 16'(win_len + timeout_len)
                                  : timeout_len;            // [RQ3]
  wire [15:0] cnt_inc  = 16'(cnt_q + 16'd1);
  wire        tick     = run & watchdog_count_clock;
  wire        to_hit   = tick & (cnt_inc == to_total);      // [RQ19]
  wire        warn_norm = (cnt_inc == warn_len) &
                          (warn_len < timeout_len);         // [RQ16]
  wire        warn_win = cnt_inc == win_len;                // [RQ15]
  wire        warn_hit = tick & (win_mode ? warn_win : warn_norm); // [RQ4]
  wire        svc_apply = sync_done & (pend_idx_q == IDX_SERVICE_KEY);
  wire        key_ok   = pend_data_q == SERVICE_KEY_VALUE;
  wire        closed   = run & win_mode & (cnt_q < win_len);
  wire        bad_svc  = svc_apply & (~key_ok | closed);    // [RQ13] [RQ20]
  wire        restart  = svc_apply & key_ok & ~closed;      // [RQ12]

  always_comb begin
    if (!run || restart || to_hit)
      cnt_d = 16'h0000;                                     // [RQ12]
    else if (tick)
      cnt_d = cnt_inc;
    else
      cnt_d = cnt_q;
  end

  wire ien_d  = (ien_q | (wr_iset & wdat[EARLY_WARN_BIT])) &
                ~(wr_iclr & wdat[EARLY_WARN_BIT]);          // [RQ7] [RQ8]
  wire flag_d = warn_hit |
                (early_warn_q & ~(wr_flag & wdat[EARLY_WARN_BIT])); // [RQ10]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q        <= 16'h0000;
      ien_q        <= 1'b0;
      early_warn_q <= 1'b0;
      irq_q        <= 1'b0;
      sys_reset_q  <= 1'b0;
    end else begin
      cnt_q        <= cnt_d;
      ien_q        <= ien_d;
      early_warn_q <= flag_d;                               // [RQ9]
      irq_q        <= early_warn_q & ien_q;                 // [RQ17]
      sys_reset_q  <= to_hit | bad_svc;                     // [RQ13] [RQ19]
    end
  end

  assign hrdata        = hrdata_q;
  assign hreadyout     = hready_q;
  assign hresp         = hresp_q;
  assign irq           = irq_q;
  assign sys_reset_req = sys_reset_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  flag_set_a: assert property (warn_hit |=> early_warn_q) // [RQ9]
    else $error("warning flag not set at warning point");
  flag_clear_a: assert property (
    wr_flag && wdat[EARLY_WARN_BIT] && !warn_hit |=> !early_warn_q) // [RQ10]
    else $error("warning flag not cleared by write of one");
  ien_set_a: assert property (
    wr_iset && wdat[EARLY_WARN_BIT] |=> ien_q) // [RQ8]
    else $error("enable set failed");
  ien_clear_a: assert property (
    wr_iclr && wdat[EARLY_WARN_BIT] |=> !ien_q) // [RQ7]
    else $error("enable clear failed");
  irq_follow_a: assert property (
    early_warn_q && ien_q |=> irq_q) // [RQ17]
    else $error("interrupt not raised for enabled flag");
  busy_span_a: assert property (
    sync_start |=> busy_q [*3] ##1 !busy_q) // [RQ11]
    else $error("busy span wrong");
  key_restart_a: assert property (restart |=> cnt_q == 16'h0000) // [RQ12]
    else $error("key write did not restart count");
  bad_key_a: assert property (
    svc_apply && !key_ok |=> sys_reset_req) // [RQ13]
    else $error("wrong key did not reset");
  timeout_reset_a: assert property (
    to_hit |=> sys_reset_req && cnt_q == 16'h0000) // [RQ19]
    else $error("time-out did not reset");
  closed_key_a: assert property (
    svc_apply && key_ok && closed |=> sys_reset_req) // [RQ20]
    else $error("closed window key not punished");
  enable_prot_a: assert property (
    wr_en && ph_q.idx == IDX_TIMING_CONFIG && !wdt_off && loaded_q
    |=> $stable(cfg_q)) // [RQ18]
    else $error("protected config written while enabled");

endmodule : wdt_core

// ===== testbench/ahb_host.sv
// Processor-side AHB-Lite master issuing single word transfers
`timescale 1ns/1ns
module ahb_host (
  // Clock and bus answer
  input  wire logic        mclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Bus request
  output logic             hsel   = 1'b0,
  output logic      [31:0] haddr  = 32'h0,
  output logic      [1:0]  htrans = 2'b00,
  output logic             hwrite = 1'b0,
  output logic      [2:0]  hsize  = 3'b010,
  output logic      [31:0] hwdata = 32'h0
);
  // One transfer; the caller decides when service writes land, the closed window included
  task automatic xfer(input logic wr, input logic [3:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {26'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    // Released lines must not keep showing the last value
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~haddr;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : ahb_host

// ===== testbench/watchdog_timer_config_and_service_tb.sv
// Register and timing tests of the watchdog core
`timescale 1ns/1ns
module watchdog_timer_config_and_service_tb;
  import wdt_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        tick = 1'b0;
  logic        write_lock = 1'b0;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  wire         hsel, hwrite, hready, hresp, irq, sys_reset_req;
  int          n_fail = 0, n_tests = 0, n_rst = 0, n_irq = 0, snap;

  always #5 mclk = ~mclk;

  ahb_host m (.mclk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  wdt_core dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .watchdog_count_clock(tick), .write_lock(write_lock),
    .nvm_control(8'h00), .nvm_timing_config(8'h32),
    .nvm_early_warn_offset(4'h1), .irq(irq), .sys_reset_req(sys_reset_req));

  always @(negedge mclk) begin
    if (sys_reset_req === 1'b1) n_rst++;
    if (irq === 1'b1) n_irq++;
  end

  task automatic chk(input logic [31:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic rd(input logic [3:0] idx, input logic [7:0] exp,
                    input string msg);
    logic [31:0] d;
    m.xfer(1'b0, idx, 32'h0, d);
    chk(d, {24'h0, exp}, msg);
  endtask : rd

  task automatic wr(input logic [3:0] idx, input logic [7:0] v);
    logic [31:0] d;
    m.xfer(1'b1, idx, {24'h0, v}, d);
  endtask : wr

  // Cycles until irq (sel 0) or reset request (sel 1) must lie in lo..hi
  task automatic wait_out(input logic sel, input int lo, hi, input string msg);
    int n;
    n = 0;
    while ((sel ? sys_reset_req : irq) !== 1'b1 && n <= hi) begin
      @(negedge mclk);
      n++;
    end
    chk({31'h0, n >= lo && n <= hi}, 32'h1, msg);
    @(posedge mclk);
  endtask : wait_out

  task automatic complete_run;
    $display("Tests %0d, failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    n_fail++;
    complete_run;
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    tick  <= 1'b1;
    repeat (5) @(posedge mclk);
    rd(IDX_IRQ_ENABLE_CLEAR, 8'h00, "enable clear reset");
    rd(IDX_IRQ_ENABLE_SET, 8'h00, "enable set reset");
    rd(IDX_IRQ_FLAGS, 8'h00, "flags reset");
    rd(IDX_SYNC_STATUS, 8'h00, "status reset");
    rd(IDX_SERVICE_KEY, 8'h00, "service reads zero");
    rd(IDX_TIMING_CONFIG, 8'h32, "config start-up");
    rd(IDX_EARLY_WARNING_CONTROL, 8'h01, "offset start-up");
    rd(4'h3, 8'h00, "unmapped reads zero");
    wr(IDX_IRQ_ENABLE_SET, 8'h00);
    rd(IDX_IRQ_ENABLE_SET, 8'h00, "set zero no effect");
    wr(IDX_IRQ_ENABLE_SET, 8'h01);
    rd(IDX_IRQ_ENABLE_CLEAR, 8'h01, "enable on");
    wr(IDX_IRQ_ENABLE_CLEAR, 8'h00);
    rd(IDX_IRQ_ENABLE_SET, 8'h01, "clear zero no effect");
    wr(IDX_IRQ_ENABLE_CLEAR, 8'h01);
    rd(IDX_IRQ_ENABLE_SET, 8'h00, "enable off");
    wr(IDX_IRQ_ENABLE_SET, 8'h01);
    write_lock <= 1'b1;
    wr(IDX_IRQ_ENABLE_CLEAR, 8'h01);
    rd(IDX_IRQ_ENABLE_SET, 8'h01, "locked write dropped");
    write_lock <= 1'b0;
    wr(IDX_TIMING_CONFIG, 8'h02);
    rd(IDX_TIMING_CONFIG, 8'h02, "config written");
    wr(IDX_CONTROL, 8'h02);
    rd(IDX_SYNC_STATUS, 8'h80, "busy after enable");
    wr(IDX_SERVICE_KEY, SERVICE_KEY_VALUE);
    wait_out(1'b0, 16, 24, "early warning at 16");
    wait_out(1'b1, 10, 20, "time-out at 32");
    rd(IDX_IRQ_FLAGS, 8'h01, "flag set");
    wr(IDX_IRQ_FLAGS, 8'h00);
    rd(IDX_IRQ_FLAGS, 8'h01, "flag kept");
    wr(IDX_IRQ_FLAGS, 8'h01);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h0, "irq drops with flag");
    @(posedge mclk);
    wr(IDX_TIMING_CONFIG, 8'h0b);
    rd(IDX_TIMING_CONFIG, 8'h02, "protected while on");
    wr(IDX_SERVICE_KEY, 8'h5a);
    wait_out(1'b1, 1, 8, "bad key resets");
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_SERVICE_KEY, SERVICE_KEY_VALUE);
    wr(IDX_EARLY_WARNING_CONTROL, 8'h03);
    rd(IDX_EARLY_WARNING_CONTROL, 8'h03, "offset written");
    wr(IDX_IRQ_FLAGS, 8'h01);
    wr(IDX_CONTROL, 8'h02);
    wr(IDX_SERVICE_KEY, SERVICE_KEY_VALUE);
    snap = n_irq;
    wait_out(1'b1, 26, 40, "reset before late warning");
    chk(n_irq - snap, 0, "no warning");
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_SERVICE_KEY, SERVICE_KEY_VALUE);
    wr(IDX_TIMING_CONFIG, 8'h21);
    wr(IDX_CONTROL, 8'h06);
    wr(IDX_SERVICE_KEY, SERVICE_KEY_VALUE);
    wait_out(1'b0, 30, 40, "warning at open window");
    wr(IDX_IRQ_FLAGS, 8'h01);
    wr(IDX_SERVICE_KEY, SERVICE_KEY_VALUE);
    snap = n_rst;
    wait_out(1'b0, 26, 40, "open window service");
    chk(n_rst - snap, 0, "no reset in open window");
    wait_out(1'b1, 10, 20, "open window of 16");
    wr(IDX_IRQ_ENABLE_CLEAR, 8'h01);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h0, "irq drops with enable");
    @(posedge mclk);
    wr(IDX_SERVICE_KEY, SERVICE_KEY_VALUE);
    wait_out(1'b1, 1, 8, "closed window key resets");
    chk({31'h0, hresp}, 32'h0, "response okay");
    complete_run;
  end
endmodule : watchdog_timer_config_and_service_tb
